// ### include/rxpop_cfg.svh
// constants for the receive parallel output port
// Summary of operation
// - channel A word valid on both clock edges
// - unsynced B-D words follow own recovered clocks
// - synced mode: all words follow channel A clock
// - raw mode: ninth bit is code bit nine
// - raw mode: tenth bit is code bit ten
// - coded mode: ninth bit flags K character
// - coded mode: channel A tenth bit flags errors
// - coded mode: B-D tenth bit flags errors
// - synced mode: B-D clocks copy channel A
`ifndef RXPOP_CFG_SVH
`define RXPOP_CFG_SVH

// ==========================================================
// widths and positions
`define RXPOP_NUM_CH      4
`define RXPOP_WORD_W      10
`define RXPOP_DATA_W      8
`define RXPOP_BIT_NINTH   8
`define RXPOP_BIT_TENTH   9

// ==========================================================
// pin input vector positions
`define RXPOP_PIN_W       6
`define RXPOP_PIN_SYNC    4
`define RXPOP_PIN_CODE    5

// ==========================================================
// reset values and timing
`define RXPOP_WORD_RST    10'h000
`define RXPOP_PIN_RST     6'h00
`define RXPOP_CLK_LAG_CYC 4

`endif

// ### include/rxpop_pkg.sv
// types shared by the receive parallel output port
`include "rxpop_cfg.svh"
package rxpop_pkg;
  typedef logic [`RXPOP_WORD_W-1:0] rxpop_word_t;
  typedef logic [`RXPOP_DATA_W-1:0] rxpop_byte_t;
endpackage

// ### include/rxpop_lane_if.sv
// per-channel word carrier between the port control and a lane
`timescale 1ns/10ps
interface rxpop_lane_if
  import rxpop_pkg::*;
  ();
  logic        launch;
  logic        code_sel;
  rxpop_word_t raw;
  rxpop_byte_t dec;
  logic        k_flag;
  logic        err_flag;
  rxpop_word_t word;

  modport ctrl (output launch, code_sel, raw, dec, k_flag, err_flag, input word);
  modport lane (input launch, code_sel, raw, dec, k_flag, err_flag, output word);
endinterface

// ### rtl/rxpop_lane.sv
// one channel's output word register and bit selection
`timescale 1ns/10ps
`include "rxpop_cfg.svh"
module rxpop_lane
  import rxpop_pkg::*;
(
  input wire logic   clk_in,
  input wire logic   rst_in,
  rxpop_lane_if.lane lif
);

  // ==========================================================
  // bit selection
  wire rxpop_byte_t sel_data;
  wire logic        sel_ninth;
  wire logic        sel_tenth;
  wire rxpop_word_t next_word;

  assign sel_data  = lif.code_sel ? lif.dec : lif.raw[`RXPOP_DATA_W-1:0];
  assign sel_ninth = lif.code_sel ? lif.k_flag : lif.raw[`RXPOP_BIT_NINTH];
  assign sel_tenth = lif.code_sel ? lif.err_flag : lif.raw[`RXPOP_BIT_TENTH];
  assign next_word = {sel_tenth, sel_ninth, sel_data};

  // ==========================================================
  // word register, loaded once per receive clock edge
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      lif.word <= `RXPOP_WORD_RST;
    else if (lif.launch)
      lif.word <= next_word;
  end

  // ==========================================================
  // checks
  raw_ninth_a: assert property (@(posedge clk_in) disable iff (rst_in)
    lif.launch && !lif.code_sel |=> lif.word[`RXPOP_BIT_NINTH] == $past(lif.raw[8]))
    else $error("raw ninth bit wrong");
  raw_tenth_a: assert property (@(posedge clk_in) disable iff (rst_in)
    lif.launch && !lif.code_sel |=> lif.word[`RXPOP_BIT_TENTH] == $past(lif.raw[9]))
    else $error("raw tenth bit wrong");
  k_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
    lif.launch && lif.code_sel |=> lif.word[`RXPOP_BIT_NINTH] == $past(lif.k_flag))
    else $error("k flag wrong");
  err_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
    lif.launch && lif.code_sel |=> lif.word[`RXPOP_BIT_TENTH] == $past(lif.err_flag))
    else $error("error flag wrong");
  dec_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
    lif.launch && lif.code_sel |=> lif.word[7:0] == $past(lif.dec))
    else $error("decoded byte wrong");
  word_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !lif.launch |=> $stable(lif.word))
    else $error("word moved between edges");

endmodule // rxpop_lane

// ### rtl/rxpop_top.sv
// receive parallel output port: four channels of ddr output words
`timescale 1ns/10ps
`include "rxpop_cfg.svh"
module rxpop_top
  import rxpop_pkg::*;
#(
  parameter int CLK_LAG = `RXPOP_CLK_LAG_CYC
)
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CHANNEL_SYNC_SEL_IN,
  input  wire logic        CODE_SEL_IN,
  input  wire logic        REC_CLK_CH_A_IN,
  input  wire logic        REC_CLK_CH_B_IN,
  input  wire logic        REC_CLK_CH_C_IN,
  input  wire logic        REC_CLK_CH_D_IN,
  input  wire rxpop_word_t CODE_GROUP_CH_A_IN,
  input  wire rxpop_word_t CODE_GROUP_CH_B_IN,
  input  wire rxpop_word_t CODE_GROUP_CH_C_IN,
  input  wire rxpop_word_t CODE_GROUP_CH_D_IN,
  input  wire rxpop_byte_t DEC_BYTE_CH_A_IN,
  input  wire rxpop_byte_t DEC_BYTE_CH_B_IN,
  input  wire rxpop_byte_t DEC_BYTE_CH_C_IN,
  input  wire rxpop_byte_t DEC_BYTE_CH_D_IN,
  input  wire logic        DEC_K_CH_A_IN,
  input  wire logic        DEC_K_CH_B_IN,
  input  wire logic        DEC_K_CH_C_IN,
  input  wire logic        DEC_K_CH_D_IN,
  input  wire logic        DEC_ERR_CH_A_IN,
  input  wire logic        DEC_ERR_CH_B_IN,
  input  wire logic        DEC_ERR_CH_C_IN,
  input  wire logic        DEC_ERR_CH_D_IN,
  output wire rxpop_word_t RX_DATA_CH_A_OUT,
  output wire rxpop_word_t RX_DATA_CH_B_OUT,
  output wire rxpop_word_t RX_DATA_CH_C_OUT,
  output wire rxpop_word_t RX_DATA_CH_D_OUT,
  output wire logic        RX_CLK_CH_A_OUT,
  output wire logic        RX_CLK_CH_B_OUT,
  output wire logic        RX_CLK_CH_C_OUT,
  output wire logic        RX_CLK_CH_D_OUT
);

  localparam int NCH     = `RXPOP_NUM_CH;
  // edge pulse to output clock change: lag taps plus the output register
  localparam int LAG_DLY = CLK_LAG + 1;

  // ==========================================================
  // pin synchronisers: three stages, level accepted when 2 and 3 agree
  logic [`RXPOP_PIN_W-1:0] pin_s1;
  logic [`RXPOP_PIN_W-1:0] pin_s2;
  logic [`RXPOP_PIN_W-1:0] pin_s3;
  logic [`RXPOP_PIN_W-1:0] pin_filt;
  wire  [`RXPOP_PIN_W-1:0] pin_raw;
  wire  [`RXPOP_PIN_W-1:0] pin_agree;
  wire  [`RXPOP_PIN_W-1:0] next_pin_filt;

  assign pin_raw       = {CODE_SEL_IN, CHANNEL_SYNC_SEL_IN, REC_CLK_CH_D_IN,
                          REC_CLK_CH_C_IN, REC_CLK_CH_B_IN, REC_CLK_CH_A_IN};
  assign pin_agree     = ~(pin_s2 ^ pin_s3);
  assign next_pin_filt = (pin_s2 & pin_agree) | (pin_filt & ~pin_agree);

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      pin_s1   <= `RXPOP_PIN_RST;
      pin_s2   <= `RXPOP_PIN_RST;
      pin_s3   <= `RXPOP_PIN_RST;
      pin_filt <= `RXPOP_PIN_RST;
    end
    else
    begin
      pin_s1   <= pin_raw;
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_filt <= next_pin_filt;
    end
  end

  // ==========================================================
  // receive clock edge detect, both edges
  logic [NCH-1:0] edge_p;
  wire  [NCH-1:0] next_edge_p;
  wire  [NCH-1:0] rclk_lvl;
  wire            chan_sync;
  wire            code_sel;

  assign rclk_lvl    = pin_filt[NCH-1:0];
  assign chan_sync   = pin_filt[`RXPOP_PIN_SYNC];
  assign code_sel    = pin_filt[`RXPOP_PIN_CODE];
  assign next_edge_p = next_pin_filt[NCH-1:0] ^ pin_filt[NCH-1:0];

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
      edge_p <= '0;
    else
      edge_p <= next_edge_p;
  end

  // ==========================================================
  // launch selection: own clock or channel A clock
  wire [NCH-1:0] launch;

  assign launch[0]       = edge_p[0];
  assign launch[NCH-1:1] = chan_sync ? {(NCH-1){edge_p[0]}} : edge_p[NCH-1:1];

  // ==========================================================
  // per-channel input arrays
  rxpop_word_t code_grp [NCH];
  rxpop_byte_t dec_byte [NCH];
  wire [NCH-1:0] dec_k;
  wire [NCH-1:0] dec_err;
  rxpop_word_t word_arr [NCH];

  assign code_grp[0] = CODE_GROUP_CH_A_IN;
  assign code_grp[1] = CODE_GROUP_CH_B_IN;
  assign code_grp[2] = CODE_GROUP_CH_C_IN;
  assign code_grp[3] = CODE_GROUP_CH_D_IN;
  assign dec_byte[0] = DEC_BYTE_CH_A_IN;
  assign dec_byte[1] = DEC_BYTE_CH_B_IN;
  assign dec_byte[2] = DEC_BYTE_CH_C_IN;
  assign dec_byte[3] = DEC_BYTE_CH_D_IN;
  assign dec_k       = {DEC_K_CH_D_IN, DEC_K_CH_C_IN, DEC_K_CH_B_IN, DEC_K_CH_A_IN};
  assign dec_err     = {DEC_ERR_CH_D_IN, DEC_ERR_CH_C_IN, DEC_ERR_CH_B_IN, DEC_ERR_CH_A_IN};

  // ==========================================================
  // lanes and delayed output clocks
  // the clock is lagged so each output edge falls inside a settled word
  logic [CLK_LAG-1:0] lag [NCH];
  logic [NCH-1:0]     clk_out;
  wire  [NCH-1:0]     next_clk_out;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : gen_ch
      rxpop_lane_if lif ();

      assign lif.launch   = launch[g];
      assign lif.code_sel = code_sel;
      assign lif.raw      = code_grp[g];
      assign lif.dec      = dec_byte[g];
      assign lif.k_flag   = dec_k[g];
      assign lif.err_flag = dec_err[g];
      assign word_arr[g]  = lif.word;

      rxpop_lane u_lane (
        .clk_in (CLOCK_IN),
        .rst_in (RST_IN),
        .lif    (lif)
      );

      if (CLK_LAG > 1)
      begin : gen_lag
        always_ff @(posedge CLOCK_IN)
        begin
          if (RST_IN)
            lag[g] <= '0;
          else
            lag[g] <= {lag[g][CLK_LAG-2:0], rclk_lvl[g]};
        end
      end
      else
      begin : gen_lag1
        always_ff @(posedge CLOCK_IN)
        begin
          if (RST_IN)
            lag[g] <= '0;
          else
            lag[g] <= rclk_lvl[g];
        end
      end

      if (g == 0)
      begin : gen_clk_a
        assign next_clk_out[g] = lag[0][CLK_LAG-1];
      end
      else
      begin : gen_clk_bd
        assign next_clk_out[g] = chan_sync ? lag[0][CLK_LAG-1] : lag[g][CLK_LAG-1];
      end
    end
  endgenerate

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
      clk_out <= '0;
    else
      clk_out <= next_clk_out;
  end

  // ==========================================================
  // outputs
  assign RX_DATA_CH_A_OUT = word_arr[0];
  assign RX_DATA_CH_B_OUT = word_arr[1];
  assign RX_DATA_CH_C_OUT = word_arr[2];
  assign RX_DATA_CH_D_OUT = word_arr[3];
  assign RX_CLK_CH_A_OUT  = clk_out[0];
  assign RX_CLK_CH_B_OUT  = clk_out[1];
  assign RX_CLK_CH_C_OUT  = clk_out[2];
  assign RX_CLK_CH_D_OUT  = clk_out[3];

  // ==========================================================
  // checks
  clk_a_lag_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    edge_p[0] |-> ##LAG_DLY $changed(RX_CLK_CH_A_OUT))
    else $error("channel A clock edge not at word centre");
  data_a_hold_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    $changed(RX_CLK_CH_A_OUT) |-> $stable(RX_DATA_CH_A_OUT))
    else $error("channel A word moved at clock edge");
  own_clk_b_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    !chan_sync && !code_sel && edge_p[1] |=> RX_DATA_CH_B_OUT == $past(code_grp[1]))
    else $error("channel B not launched by own clock");
  own_clk_d_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    !chan_sync && !$past(chan_sync) && $changed(RX_DATA_CH_D_OUT) |-> $past(edge_p[3]))
    else $error("channel D word moved without own clock edge");
  sync_launch_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    chan_sync && $past(chan_sync) && $changed(RX_DATA_CH_C_OUT) |-> $past(edge_p[0]))
    else $error("synced channel C word not on channel A edge");
  clk_copy_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    chan_sync && $past(chan_sync) |-> RX_CLK_CH_B_OUT == RX_CLK_CH_A_OUT
      && RX_CLK_CH_C_OUT == RX_CLK_CH_A_OUT && RX_CLK_CH_D_OUT == RX_CLK_CH_A_OUT)
    else $error("synced clocks differ from channel A");

  sync_word_c: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
    chan_sync ##1 launch[3]);
  indep_word_c: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
    !chan_sync && edge_p[1] && !edge_p[0]);
  k_char_c: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
    code_sel && launch[0] && dec_k[0]);
  err_word_c: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
    code_sel && launch[2] && dec_err[2]);

endmodule // rxpop_top

// ### bench/rxpop_mac_model.sv
// far-side receive logic model: captures each word on both output clock edges
`timescale 1ns/10ps
module rxpop_mac_model
  import rxpop_pkg::*;
(
  input  wire logic        rx_clk_in [4],
  input  wire rxpop_word_t rx_data_in [4],
  output logic [3:0]       cap_evt_out,
  output rxpop_word_t      cap_word_out [4]
);
  // ==========================================================
  // capture, rising and falling edges alike
  initial cap_evt_out = 4'h0;
  for (genvar g = 0; g < 4; g++)
  begin : g_cap
    always @(rx_clk_in[g])
    begin
      cap_word_out[g] = rx_data_in[g];
      cap_evt_out[g] = ~cap_evt_out[g];
    end
  end
endmodule // rxpop_mac_model

// ### bench/rxpop_top_test.sv
// self-checking bench for the receive parallel output port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module rxpop_top_test
  import rxpop_pkg::*;
;
  logic        clk, rst, sync_m, code_m, run, live;
  logic        rc [4];
  logic        oc [4];
  logic        dk [4];
  logic        de [4];
  rxpop_word_t cg [4];
  rxpop_word_t rd [4];
  rxpop_word_t cap_word [4];
  rxpop_byte_t db [4];
  logic [3:0]  cap_evt;
  rxpop_word_t exp_q [4][$];
  int          failures, num_checks;
  integer      seed;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  rxpop_top #(.CLK_LAG(4)) dut (
    .CLOCK_IN(clk), .RST_IN(rst), .CHANNEL_SYNC_SEL_IN(sync_m), .CODE_SEL_IN(code_m),
    .REC_CLK_CH_A_IN(rc[0]), .REC_CLK_CH_B_IN(rc[1]),
    .REC_CLK_CH_C_IN(rc[2]), .REC_CLK_CH_D_IN(rc[3]),
    .CODE_GROUP_CH_A_IN(cg[0]), .CODE_GROUP_CH_B_IN(cg[1]),
    .CODE_GROUP_CH_C_IN(cg[2]), .CODE_GROUP_CH_D_IN(cg[3]),
    .DEC_BYTE_CH_A_IN(db[0]), .DEC_BYTE_CH_B_IN(db[1]),
    .DEC_BYTE_CH_C_IN(db[2]), .DEC_BYTE_CH_D_IN(db[3]),
    .DEC_K_CH_A_IN(dk[0]), .DEC_K_CH_B_IN(dk[1]),
    .DEC_K_CH_C_IN(dk[2]), .DEC_K_CH_D_IN(dk[3]),
    .DEC_ERR_CH_A_IN(de[0]), .DEC_ERR_CH_B_IN(de[1]),
    .DEC_ERR_CH_C_IN(de[2]), .DEC_ERR_CH_D_IN(de[3]),
    .RX_DATA_CH_A_OUT(rd[0]), .RX_DATA_CH_B_OUT(rd[1]),
    .RX_DATA_CH_C_OUT(rd[2]), .RX_DATA_CH_D_OUT(rd[3]),
    .RX_CLK_CH_A_OUT(oc[0]), .RX_CLK_CH_B_OUT(oc[1]),
    .RX_CLK_CH_C_OUT(oc[2]), .RX_CLK_CH_D_OUT(oc[3])
  );

  rxpop_mac_model mac (
    .rx_clk_in(oc), .rx_data_in(rd), .cap_evt_out(cap_evt), .cap_word_out(cap_word)
  );

  // ==========================================================
  // stimulus
  // one link clock toggle with fresh words on the channels it times
  task automatic toggle(input int ch);
    int lo;
    int hi;
    lo = sync_m ? 0 : ch;
    hi = sync_m ? 3 : ch;
    rc[ch] = ~rc[ch];
    // same-clock words move on the falling edge, well before the launch
    @(negedge clk);
    for (int c = lo; c <= hi; c++)
    begin
      cg[c] = 10'($random(seed));
      db[c] = 8'($random(seed));
      dk[c] = 1'($random(seed));
      de[c] = 1'($random(seed));
      exp_q[c].push_back(code_m ? {de[c], dk[c], db[c]} : cg[c]);
    end
  endtask

  // even toggle count so every link clock rests low between frames
  task automatic lane_run(input int ch);
    realtime t0;
    if (ch == 0 || !sync_m)
    begin
      // offsets keep every link clock toggle off both system clock edges
      #(1.3 + 3.3 * ch);
      repeat (16)
      begin
        t0 = $realtime;
        toggle(ch);
        #(62.5 - ($realtime - t0));
      end
    end
  endtask

  task automatic frame(input logic s, input logic k);
    @(negedge clk);
    sync_m = s;
    code_m = k;
    repeat (12) @(negedge clk);
    live = 1'b1;
    fork
      lane_run(0);
      lane_run(1);
      lane_run(2);
      lane_run(3);
    join
    repeat (20) @(negedge clk);
    live = 1'b0;
    for (int c = 0; c < 4; c++)
      `CHK("words left", 0, exp_q[c].size())
  endtask

  // ==========================================================
  // monitor
  for (genvar g = 0; g < 4; g++)
  begin : g_mon
    rxpop_word_t exp_w;
    always @(cap_evt[g])
      if (run)
      begin
        if (exp_q[g].size() == 0)
          `CHK("spurious word", 1'b0, 1'b1)
        else
        begin
          exp_w = exp_q[g].pop_front();
          `CHK("word", exp_w, cap_word[g])
        end
      end
  end

  always @(negedge clk)
    if (live && sync_m)
      for (int c = 1; c < 4; c++)
        `CHK("copied clock", oc[0], oc[c])

  // ==========================================================
  // sequence and verdict
  task conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #300000;
    failures++;
    $display("unexpected timeout: expected done seen hang");
    conclude();
  end

  initial
  begin
    failures = 0;
    num_checks = 0;
    seed = 32'h4ae31605;
    run = 1'b0;
    live = 1'b0;
    rst = 1'b1;
    sync_m = 1'b0;
    code_m = 1'b0;
    rc = '{4{1'b0}};
    dk = '{4{1'b0}};
    de = '{4{1'b0}};
    cg = '{4{10'h000}};
    db = '{4{8'h00}};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    for (int c = 0; c < 4; c++)
    begin
      `CHK("reset word", 10'h000, rd[c])
      `CHK("reset clock", 1'b0, oc[c])
    end
    run = 1'b1;
    for (int m = 0; m < 4; m++)
      frame(m[1], m[0]);
    frame(1'b0, 1'b0);
    conclude();
  end
endmodule // rxpop_top_test
